// ### hdl/icc_ctrl.sv
// Sectored fully associative instruction cache controller
`timescale 1ns/100ps
`include "icc_regs.svh"

module icc_ctrl (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // Register port
  input  wire logic [1:0]            reg_addr_i,
  input  wire logic [23:0]           reg_wdata_i,
  input  wire logic                  reg_we_i,
  input  wire logic                  reg_re_i,
  output logic      [23:0]           reg_rdata_o,
  // Fetch port
  input  wire logic                  fetch_req_i,
  input  wire logic [23:0]           fetch_addr_i,
  output icc_pkg::icc_fetch_rsp_t    fetch_rsp_o,
  output logic                       busy_o,
  // Cache instruction port
  input  wire logic                  op_valid_i,
  input  wire icc_pkg::icc_op_t      op_code_i,
  input  wire logic [23:0]           op_addr_i,
  output logic                       op_ack_o,
  output logic                       illegal_o,
  // External program memory
  output icc_pkg::icc_mem_req_t      mem_req_o,
  input  wire logic [23:0]           mem_rdata_i
);

  typedef struct packed {
    icc_pkg::icc_state_t               st;
    logic [`ICC_SEC_N-1:0][127:0]      valid;
    logic [`ICC_SEC_N-1:0][16:0]       tag;
    logic [`ICC_SEC_N-1:0][2:0]        lru;
    logic [`ICC_SEC_N-1:0]             lock;
    logic                              ce;
    logic                              burst;
    logic [`ICC_WAIT_W-1:0]            wait_n;
    logic [2:0]                        sec;
    logic [23:0]                       addr;
    logic [2:0]                        left;
    logic [`ICC_WAIT_W-1:0]            wcnt;
    logic                              first;
    logic                              keep;
    logic                              busy;
    icc_pkg::icc_fetch_rsp_t           rsp;
    icc_pkg::icc_mem_req_t             mem;
    logic                              op_ack;
    logic                              illegal;
    logic [23:0]                       rdata;
  } icc_state_q_t;

  icc_state_q_t      s_q;
  icc_state_q_t      s_d;
  logic [23:0]       mem_q [`ICC_WORDS];
  logic              wr_en;
  logic [9:0]        wr_idx;
  logic [23:0]       wr_data;
  logic [9:0]        rd_idx;
  logic [23:0]       rd_word;

  // Move sector s to the top, keeping the relative order of the rest
  function automatic logic [7:0][2:0] touch(input logic [7:0][2:0] st,
                                            input logic [2:0]      s);
    logic [7:0][2:0] n;
    logic            p;
    n    = st;
    p    = 1'b0;
    n[0] = s;
    for (int i = 1; i < 8; i++) begin
      if (st[i-1] == s) begin
        p = 1'b1;
      end
      n[i] = p ? st[i] : st[i-1];
    end
    return n;
  endfunction

  // Default order: sector 0 on top, sector 7 at the bottom
  function automatic logic [7:0][2:0] lru_default();
    logic [7:0][2:0] n;
    n = '0;
    for (int i = 0; i < 8; i++) begin
      n[i] = 3'(i);
    end
    return n;
  endfunction

  // Deepest unlocked sector in the stack; found is low when all are locked
  function automatic logic [3:0] victim(input logic [7:0][2:0] st,
                                        input logic [7:0]      lk);
    logic [3:0] v;
    v = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (!lk[st[i]]) begin
        v = {1'b1, st[i]};
      end
    end
    return v;
  endfunction

  // Parallel tag match; bit 3 flags a hit
  function automatic logic [3:0] lookup(input logic [7:0][16:0] tg,
                                        input logic [16:0]      t);
    logic [3:0] h;
    h = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (tg[i] == t) begin
        h = {1'b1, 3'(i)};
      end
    end
    return h;
  endfunction

  logic [3:0]  f_hit;
  logic [3:0]  o_hit;
  logic [3:0]  vic;
  logic [6:0]  f_off;
  logic [16:0] f_tag;

  assign f_off   = fetch_addr_i[`ICC_OFF_W-1:0];
  assign f_tag   = fetch_addr_i[23:`ICC_OFF_W];
  assign f_hit   = lookup(s_q.tag, f_tag);
  assign o_hit   = lookup(s_q.tag, op_addr_i[23:`ICC_OFF_W]);
  assign vic     = victim(s_q.lru, s_q.lock);
  assign rd_idx  = {f_hit[2:0], f_off};
  assign rd_word = mem_q[rd_idx];

  always_comb begin
    s_d         = s_q;
    s_d.rsp     = '0;
    s_d.op_ack  = 1'b0;
    s_d.illegal = 1'b0;
    s_d.rdata   = 24'h0;
    wr_en       = 1'b0;
    wr_idx      = {s_q.sec, s_q.addr[`ICC_OFF_W-1:0]};
    wr_data     = mem_rdata_i;

    // Register port; valid bits have no address on purpose
    if (reg_we_i) begin
      case (reg_addr_i)
        `ICC_OFF_PSTAT: s_d.ce = reg_wdata_i[`ICC_CE_BIT];
        `ICC_OFF_MODE:  s_d.burst = reg_wdata_i[`ICC_BURST_BIT];
        `ICC_OFF_WAIT: s_d.wait_n = reg_wdata_i[`ICC_WAIT_W-1:0];
        default: ;
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        `ICC_OFF_PSTAT: s_d.rdata[`ICC_CE_BIT] = s_q.ce;
        `ICC_OFF_MODE:  s_d.rdata[`ICC_BURST_BIT] = s_q.burst;
        `ICC_OFF_WAIT: s_d.rdata[`ICC_WAIT_W-1:0] = s_q.wait_n;
        default:       s_d.rdata[8:0] = {s_q.busy, s_q.lock};
      endcase
    end

    case (s_q.st)
      icc_pkg::ICC_ST_IDLE: begin
        if (fetch_req_i) begin
          s_d.addr  = fetch_addr_i;
          s_d.first = 1'b1;
          s_d.wcnt  = s_q.wait_n;
          s_d.left  = 3'h1;
          s_d.keep  = 1'b0;
          if (s_q.ce && f_hit[3] && s_q.valid[f_hit[2:0]][f_off]) begin
            s_d.rsp = '{ack: 1'b1, data: rd_word};
            s_d.lru = touch(s_q.lru, f_hit[2:0]);
          end else begin
            // Disabled or uncacheable fetches still take one timed read
            s_d.st   = icc_pkg::ICC_ST_FILL;
            s_d.busy = 1'b1;
            s_d.mem  = '{rd: 1'b1, addr: fetch_addr_i};
            if (s_q.ce && (f_hit[3] || vic[3])) begin
              s_d.keep = 1'b1;
              if (s_q.burst) begin
                s_d.left = `ICC_BURST_MAX - {1'b0, fetch_addr_i[1:0]};
              end
              if (f_hit[3]) begin
                s_d.sec = f_hit[2:0];
                s_d.lru = touch(s_q.lru, f_hit[2:0]);
              end else begin
                s_d.sec              = vic[2:0];
                s_d.valid[vic[2:0]]  = '0;
                s_d.tag[vic[2:0]]    = f_tag;
                s_d.lru              = touch(s_q.lru, vic[2:0]);
              end
            end
          end
        end else if (op_valid_i) begin
          if (!s_q.ce) begin
            s_d.illegal = 1'b1;
          end else begin
            s_d.op_ack = 1'b1;
            case (op_code_i)
              icc_pkg::ICC_OP_LOCK, icc_pkg::ICC_OP_UNLOCK: begin
                if (o_hit[3]) begin
                  s_d.lock[o_hit[2:0]] = (op_code_i == icc_pkg::ICC_OP_LOCK);
                  s_d.lru = touch(s_q.lru, o_hit[2:0]);
                end else if (vic[3]) begin
                  // Allocated empty; all locked means nothing happens
                  s_d.valid[vic[2:0]] = '0;
                  s_d.tag[vic[2:0]]   = op_addr_i[23:`ICC_OFF_W];
                  s_d.lock[vic[2:0]]  = (op_code_i == icc_pkg::ICC_OP_LOCK);
                  s_d.lru = touch(s_q.lru, vic[2:0]);
                end
              end
              icc_pkg::ICC_OP_RELEASE: s_d.lock = '0;
              icc_pkg::ICC_OP_FLUSH: begin
                s_d.valid = '0;
                s_d.tag   = {`ICC_SEC_N{`ICC_TAG_RESET}};
                s_d.lru   = lru_default();
                s_d.lock  = '0;
              end
              icc_pkg::ICC_OP_FLUSHUN: begin
                for (int i = 0; i < 8; i++) begin
                  if (!s_q.lock[i]) begin
                    s_d.valid[i] = '0;
                    s_d.tag[i]   = `ICC_TAG_RESET;
                  end
                end
                s_d.lru = lru_default();
              end
              default: s_d.op_ack = 1'b0;
            endcase
          end
        end
      end

      icc_pkg::ICC_ST_FILL: begin
        if (s_q.wcnt == '0) begin
          // Data taken in the last of wait states plus one cycles
          if (s_q.keep) begin
            wr_en = 1'b1;
            s_d.valid[s_q.sec][s_q.addr[`ICC_OFF_W-1:0]] = 1'b1;
          end
          if (s_q.first) begin
            s_d.rsp = '{ack: 1'b1, data: mem_rdata_i};
          end
          s_d.first = 1'b0;
          s_d.wcnt  = s_q.wait_n;
          s_d.left  = s_q.left - 3'h1;
          s_d.addr  = s_q.addr + 24'h1;
          s_d.mem   = '{rd: 1'b1, addr: s_q.addr + 24'h1};
          if (s_q.left == 3'h1) begin
            s_d.st   = icc_pkg::ICC_ST_IDLE;
            s_d.busy = 1'b0;
            s_d.mem  = '0;
          end
        end else begin
          s_d.wcnt = s_q.wcnt - 1'b1;
        end
      end

      default: begin
        s_d.st   = icc_pkg::ICC_ST_IDLE;
        s_d.busy = 1'b0;
        s_d.mem  = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q        <= '0;
      s_q.st     <= icc_pkg::ICC_ST_IDLE;
      s_q.ce     <= 1'b0;
      s_q.valid  <= '0;
      s_q.tag    <= {`ICC_SEC_N{`ICC_TAG_RESET}};
      s_q.lock   <= '0;
      s_q.lru    <= `ICC_LRU_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Word storage; no reset since valid bits guard every read
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  assign reg_rdata_o = s_q.rdata;
  assign fetch_rsp_o = s_q.rsp;
  assign busy_o      = s_q.busy;
  assign op_ack_o    = s_q.op_ack;
  assign illegal_o   = s_q.illegal;
  assign mem_req_o   = s_q.mem;

endmodule // icc_ctrl

// ### inc/icc_pkg.sv
// Types shared by the instruction cache controller and its users
package icc_pkg;
  typedef enum logic [1:0] {
    ICC_ST_IDLE = 2'b01,
    ICC_ST_FILL = 2'b10
  } icc_state_t;

  typedef enum logic [2:0] {
    ICC_OP_LOCK    = 3'h0,
    ICC_OP_UNLOCK  = 3'h1,
    ICC_OP_RELEASE = 3'h2,
    ICC_OP_FLUSH   = 3'h3,
    ICC_OP_FLUSHUN = 3'h4
  } icc_op_t;

  typedef struct packed {
    logic        rd;
    logic [23:0] addr;
  } icc_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [23:0] data;
  } icc_fetch_rsp_t;
endpackage

// ### inc/icc_regs.svh
// Register offsets, field positions, reset values and sizes of the cache controller
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH
`define ICC_OFF_PSTAT   2'h0
`define ICC_OFF_MODE    2'h1
`define ICC_OFF_WAIT    2'h2
`define ICC_OFF_STAT    2'h3
`define ICC_CE_BIT      19
`define ICC_BURST_BIT   10
`define ICC_WAIT_W      4
`define ICC_TAG_RESET   17'h1ffff
`define ICC_TAG_W       17
`define ICC_OFF_W       7
`define ICC_SEC_N       8
`define ICC_WORDS       1024
`define ICC_BURST_MAX   3'h4
`define ICC_LRU_RESET   {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0}
`endif

// ### verification/icc_ctrl_monitor.sv
// Port checker of the instruction cache controller
`timescale 1ns/100ps
module icc_ctrl_monitor (
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_n_i,
  // Register writes
  input wire logic [1:0]              reg_addr_i,
  input wire logic [23:0]             reg_wdata_i,
  input wire logic                    reg_we_i,
  // Fetch and fill
  input wire logic                    fetch_req_i,
  input wire icc_pkg::icc_fetch_rsp_t fetch_rsp_o,
  input wire logic                    busy_o,
  input wire icc_pkg::icc_mem_req_t   mem_req_o,
  // Cache instructions
  input wire logic                    op_valid_i,
  input wire icc_pkg::icc_op_t        op_code_i,
  input wire logic                    op_ack_o,
  input wire logic                    illegal_o
);
  logic ce_q;
  logic op_go;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the enable flag, updated on the same edge as the design's copy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ce_q <= 1'b0;
    else if (reg_we_i && reg_addr_i == 2'h0)
      ce_q <= reg_wdata_i[19];
  end
  assign op_go = op_valid_i && !busy_o && !fetch_req_i && op_code_i <= icc_pkg::ICC_OP_FLUSHUN;
  illegal_op_a: assert property (
    op_go && !ce_q |=> illegal_o && !op_ack_o) else $error("op not refused");
  op_done_a: assert property (
    op_go && ce_q |=> op_ack_o && !illegal_o) else $error("op not done");
  fetch_start_a: assert property (
    fetch_req_i && !busy_o |=> fetch_rsp_o.ack || busy_o) else $error("fetch ignored");
  read_in_fill_a: assert property (
    mem_req_o.rd |-> busy_o) else $error("read outside fill");
  fill_bound_a: assert property (
    $rose(busy_o) |-> ##[1:80] !busy_o) else $error("fill too long");
  word_order_a: assert property (
    mem_req_o.rd && $past(mem_req_o.rd) && $changed(mem_req_o.addr)
    |-> mem_req_o.addr == $past(mem_req_o.addr) + 24'h1) else $error("burst out of order");
  group_end_a: assert property (
    mem_req_o.rd && $past(mem_req_o.rd) && $changed(mem_req_o.addr)
    |-> mem_req_o.addr[1:0] != 2'h0) else $error("burst left its group");
  data_idle_a: assert property (
    !fetch_rsp_o.ack |-> fetch_rsp_o.data == 24'h0) else $error("data without ack");
  ack_cause_a: assert property (
    fetch_rsp_o.ack |-> $past(fetch_req_i) || $past(busy_o)) else $error("ack without fetch");
endmodule // icc_ctrl_monitor

// ### verification/icc_pmem_model.sv
// External program memory model behind the cache controller
`timescale 1ns/100ps
module icc_pmem_model (
  // Clock
  input  wire logic                  clk_i,
  // Read port
  input  wire icc_pkg::icc_mem_req_t mem_req_i,
  output logic [23:0]                rdata_o,
  output int                         reads_o
);
  logic [23:0] last_q = 24'h0;
  logic [23:0] addr_q = 24'h0;
  logic        rd_q = 1'b0;
  // Released bus shows the inverse, so a late sample never passes by luck
  assign rdata_o = mem_req_i.rd ? (mem_req_i.addr ^ 24'h5a5a5a) : ~last_q;
  initial reads_o = 0;
  always @(posedge clk_i) begin
    if (mem_req_i.rd)
      last_q <= rdata_o;
    if (mem_req_i.rd && (!rd_q || mem_req_i.addr != addr_q))
      reads_o <= reads_o + 1;
    rd_q <= mem_req_i.rd;
    addr_q <= mem_req_i.addr;
  end
endmodule // icc_pmem_model

// ### verification/test_icc_ctrl.sv
// Self-checking bench of the instruction cache controller
`timescale 1ns/100ps
module test_icc_ctrl;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reg_we_i = 1'b0, reg_re_i = 1'b0;
  logic fetch_req_i = 1'b0, op_valid_i = 1'b0, busy_o, op_ack_o, illegal_o, re_d = 1'b0;
  logic [1:0] reg_addr_i = 2'h0;
  logic [23:0] reg_wdata_i = 24'h0, fetch_addr_i = 24'h0, op_addr_i = 24'h0;
  logic [23:0] reg_rdata_o, mem_rdata_i;
  icc_pkg::icc_fetch_rsp_t fetch_rsp_o;
  icc_pkg::icc_mem_req_t mem_req_o;
  icc_pkg::icc_op_t op_code_i = icc_pkg::ICC_OP_LOCK;
  int reads, mismatches = 0, compares = 0, cyc = 0, t0 = 0, w;
  logic [31:0] seed = 32'd67049;
  logic [23:0] fq[$], rq[$], tg[9];
  logic [1:0] oq[$];
  int lq[$];
  icc_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .fetch_req_i(fetch_req_i), .fetch_addr_i(fetch_addr_i),
    .fetch_rsp_o(fetch_rsp_o), .busy_o(busy_o), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_addr_i(op_addr_i), .op_ack_o(op_ack_o),
    .illegal_o(illegal_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i));
  icc_pmem_model pmem (.clk_i(clk_i), .mem_req_i(mem_req_o), .rdata_o(mem_rdata_i),
    .reads_o(reads));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_num(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("Compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Write when we is set, else read and expect d one cycle later
  task automatic bus(input logic we, input logic [1:0] a, input logic [23:0] d);
    if (!we)
      rq.push_back(d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= we;
    reg_re_i <= !we;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic fetch(input logic [23:0] a, input int lat, input int n);
    int r0;
    r0 = reads;
    fq.push_back(a ^ 24'h5a5a5a);
    lq.push_back(lat);
    fetch_addr_i <= a;
    fetch_req_i <= 1'b1;
    @(posedge clk_i);
    fetch_req_i <= 1'b0;
    for (int i = 0; i < 90 && (fq.size() != 0 || busy_o !== 1'b0); i++) @(posedge clk_i);
    @(posedge clk_i);
    chk_num("external reads", n, reads - r0);
  endtask
  task automatic op(input icc_pkg::icc_op_t c, input logic [23:0] a, input logic [1:0] e);
    oq.push_back(e);
    op_code_i <= c;
    op_addr_i <= a;
    op_valid_i <= 1'b1;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (fetch_req_i && busy_o === 1'b0)
      t0 = cyc;
    if (fetch_rsp_o.ack === 1'b1) begin
      chk_word("fetch data", fq.pop_front(), fetch_rsp_o.data);
      chk_num("fetch latency", lq.pop_front(), cyc - t0);
    end
    if (re_d)
      chk_word("reg data", rq.pop_front(), reg_rdata_o);
    re_d <= reg_re_i;
    if (op_ack_o === 1'b1 || illegal_o === 1'b1)
      chk_word("op result", {22'h0, oq.pop_front()}, {22'h0, illegal_o, op_ack_o});
  end
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    #(40 * 30000);
    mismatches++;
    close_out();
  end
  initial begin
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      tg[i] = {seed[12:0], i[3:0], 7'h0};
    end
    w = int'(seed[1:0]) + 1;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    bus(0, 2'h0, 24'h0);
    bus(0, 2'h3, 24'h0);
    bus(1, 2'h2, 24'(w));
    op(icc_pkg::ICC_OP_FLUSH, 24'h0, 2'b10);
    fetch(tg[0], 2 + w, 1);
    fetch(tg[0], 2 + w, 1);
    bus(1, 2'h3, 24'hffffff);
    bus(1, 2'h0, 24'hffffff);
    bus(0, 2'h0, 24'h080000);
    bus(0, 2'h3, 24'h0);
    fetch(tg[0] + 24'h5, 2 + w, 1);
    fetch(tg[0] + 24'h5, 1, 0);
    fetch(tg[0] + 24'h6, 2 + w, 1);
    bus(1, 2'h1, 24'h000400);
    for (int k = 0; k < 4; k++) begin
      fetch(tg[1] + 24'(9 * k), 2 + w, 4 - k);
      fetch(tg[1] + 24'(8 * k + 3), 1, 0);
    end
    bus(1, 2'h1, 24'h0);
    op(icc_pkg::ICC_OP_FLUSH, 24'h0, 2'b01);
    for (int i = 0; i < 8; i++)
      fetch(tg[i], 2 + w, 1);
    op(icc_pkg::ICC_OP_LOCK, tg[0], 2'b01);
    bus(0, 2'h3, 24'h000080);
    for (int i = 1; i < 8; i++)
      fetch(tg[i], 1, 0);
    fetch(tg[8], 2 + w, 1);
    fetch(tg[0], 1, 0);
    fetch(tg[1], 2 + w, 1);
    op(icc_pkg::ICC_OP_FLUSHUN, 24'h0, 2'b01);
    fetch(tg[0], 1, 0);
    fetch(tg[2], 2 + w, 1);
    op(icc_pkg::ICC_OP_UNLOCK, tg[0], 2'b01);
    bus(0, 2'h3, 24'h0);
    op(icc_pkg::ICC_OP_LOCK, tg[3], 2'b01);
    op(icc_pkg::ICC_OP_RELEASE, 24'h0, 2'b01);
    bus(0, 2'h3, 24'h0);
    op(icc_pkg::ICC_OP_FLUSH, 24'h0, 2'b01);
    fetch(tg[0], 2 + w, 1);
    bus(1, 2'h0, 24'h0);
    op(icc_pkg::ICC_OP_UNLOCK, tg[0], 2'b10);
    close_out();
  end
endmodule // test_icc_ctrl
bind icc_ctrl icc_ctrl_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .fetch_req_i(fetch_req_i), .fetch_rsp_o(fetch_rsp_o), .busy_o(busy_o),
  .mem_req_o(mem_req_o), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
  .op_ack_o(op_ack_o), .illegal_o(illegal_o));
